// >>> inc/dlt_defines.vh
`ifndef DLT_DEFINES_VH
`define DLT_DEFINES_VH

// Register byte addresses
`define DLT_ADDR_LOCK 32'h40F0_0060
`define DLT_ADDR_SCRATCH 32'h41F0_0044
`define DLT_ADDR_REV 32'h41F0_0050
`define DLT_ADDR_TRC_CTRL 32'h41F0_0070
`define DLT_ADDR_TRC_POS 32'h41F0_0074

// Lock register fields
`define DLT_LOCK_OVER_BIT 1
`define DLT_LOCK_STS_BIT 0
`define DLT_LOCK_RESET 2'h0

// Scratch reset
`define DLT_SCRATCH_RESET 32'h0000_0000

// Trace control field
`define DLT_TRC_EN_BIT 31

// Lock word check
`define DLT_LOCK_FLASH_ADDR 32'h0000_FFFC
`define DLT_LOCK_ERASED 16'hFFFF
`define DLT_OVERRIDE_KEY 8'hA5

// Revision defaults, arbitrary values
`define DLT_CORE_ECO_DEFAULT 28'h000_0001
`define DLT_DEV_REV_DEFAULT 4'h1

`endif

// >>> sim/dlt_flash_model.sv
`timescale 1ns/1ps
module dlt_flash_model #(
   parameter LAT = 3
) (
   input wire clk,
   input wire [31:0] prog_word,
   input wire rd_req,
   input wire erase_req,
   output reg rd_ack = 1'b0,
   output reg [31:0] rdata = 32'h0000_0000,
   output reg erase_done = 1'b0
);
   reg busy_r = 1'b0;
   reg wiped_r = 1'b0;
   integer n = 0;
   always @(posedge clk) begin
      rd_ack <= 1'b0;
      // Idle bus churns, never holds
      rdata <= ~rdata;
      busy_r <= erase_req;
      erase_done <= busy_r;
      n = (rd_req && !rd_ack) ? n + 1 : 0;
      if (n == LAT) begin
         rd_ack <= 1'b1;
         rdata <= wiped_r ? 32'hFFFF_FFFF : prog_word;
      end
      if (busy_r) wiped_r <= 1'b1;
   end
endmodule

// >>> sim/dlt_props.sv
`timescale 1ns/1ps
`include "dlt_defines.vh"
module dlt_props (
   input wire ref_clk,
   input wire rst_b,
   input wire [31:0] reg_addr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire sys_rst_release,
   input wire flash_rd_req,
   input wire [31:0] flash_rdata,
   input wire flash_rd_ack,
   input wire flash_erase_req,
   input wire dap_bus_req,
   input wire dap_bus_grant,
   input wire debug_port_enable,
   input wire trc_ready,
   input wire cpu_wait,
   input wire cpu_req,
   input wire sram_en,
   input wire sram_we
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire ack = flash_rd_req && flash_rd_ack;
   wire blank = flash_rdata[15:0] == `DLT_LOCK_ERASED;
   property p_rev;
      reg_rd && reg_addr == `DLT_ADDR_REV |=> reg_rdata == {`DLT_CORE_ECO_DEFAULT, `DLT_DEV_REV_DEFAULT};
   endproperty
   a_rev: assert property (p_rev) else $error("rev word");
   property p_hold;
      !sys_rst_release && !ack |=> !sys_rst_release;
   endproperty
   a_hold: assert property (p_hold) else $error("early release");
   property p_lock;
      ack && !blank |=> sys_rst_release && !debug_port_enable;
   endproperty
   a_lock: assert property (p_lock) else $error("not locked");
   property p_open;
      ack && blank |=> debug_port_enable;
   endproperty
   a_open: assert property (p_open) else $error("not open");
   property p_grant;
      dap_bus_grant == (dap_bus_req && debug_port_enable);
   endproperty
   a_grant: assert property (p_grant) else $error("grant wrong");
   property p_erase;
      flash_erase_req |=> !flash_erase_req && !debug_port_enable;
   endproperty
   a_erase: assert property (p_erase) else $error("erase order");
   property p_wait;
      cpu_wait == (cpu_req && !trc_ready);
   endproperty
   a_wait: assert property (p_wait) else $error("needless wait");
   property p_win;
      !trc_ready |-> sram_en && sram_we;
   endproperty
   a_win: assert property (p_win) else $error("trace lost sram");
   property p_pkt;
      $fell(trc_ready) |-> sram_we ##1 sram_we;
   endproperty
   a_pkt: assert property (p_pkt) else $error("packet words");
   c_lock: cover property (ack && !blank);
   c_erase: cover property (flash_erase_req);
   c_pkt: cover property ($fell(trc_ready));
   c_wait: cover property (cpu_wait);
endmodule
bind dlt_top dlt_props u_props (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sys_rst_release(sys_rst_release), .flash_rd_req(flash_rd_req),
   .flash_rdata(flash_rdata), .flash_rd_ack(flash_rd_ack), .flash_erase_req(flash_erase_req),
   .dap_bus_req(dap_bus_req), .dap_bus_grant(dap_bus_grant), .debug_port_enable(debug_port_enable),
   .trc_ready(trc_ready), .cpu_wait(cpu_wait), .cpu_req(cpu_req), .sram_en(sram_en), .sram_we(sram_we));

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "dlt_defines.vh"
module tb_top;
   localparam AW = 13;
   reg ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, swclk = 1'b0, swdio_in = 1'b0;
   reg debug_access_enable_pin = 1'b0, dap_bus_req = 1'b0, trc_valid = 1'b0, trc_exc_ret = 1'b0;
   reg trc_atomic = 1'b0, cpu_req = 1'b0, rd_d = 1'b0, on = 1'b0, s_r = 1'b0, cpu_we = 1'b0;
   reg [31:0] reg_addr = 0, reg_wdata = 0, trc_src = 0, trc_dst = 0, trc_exc_val = 0, cpu_wdata = 0;
   reg [31:0] sram_rdata = 0, rnd = 0, sc = 0;
   reg [AW-1:0] cpu_addr = 0;
   reg [AW-2:0] ptr = 0;
   reg [31:0] rq[$];
   reg [AW+31:0] sq[$];
   wire [31:0] reg_rdata, flash_rdata, sram_wdata, flash_addr, cpu_rdata;
   wire [AW-1:0] sram_addr;
   wire sys_rst_release, flash_rd_req, flash_rd_ack, flash_erase_req, flash_erase_done;
   wire dap_bus_grant, debug_port_enable, trc_ready, cpu_wait, sram_en, sram_we;
   integer mismatches = 0, n_checks = 0, i;
   dlt_top u_dlt_top (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sys_rst_release,
      .flash_rd_req, .flash_addr, .flash_rdata, .flash_rd_ack, .flash_erase_req, .flash_erase_done,
      .debug_access_enable_pin, .swclk, .swdio_in, .dap_bus_req, .dap_bus_grant, .debug_port_enable,
      .trc_valid, .trc_ready, .trc_exc_ret, .trc_atomic, .trc_src, .trc_dst, .trc_exc_val, .cpu_req,
      .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_wait, .sram_en, .sram_we, .sram_addr,
      .sram_wdata, .sram_rdata);
   dlt_flash_model #(.LAT(3)) u_dlt_flash_model (.clk(ref_clk), .prog_word(32'h1234_5678),
      .rd_req(flash_rd_req), .erase_req(flash_erase_req), .rd_ack(flash_rd_ack), .rdata(flash_rdata),
      .erase_done(flash_erase_done));
   initial forever #12.5 ref_clk = ~ref_clk;
   task cmp(input string nm, input [63:0] e, input [63:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task boot;
      begin
         rst_b <= 1'b0;
         repeat (12) @(posedge ref_clk);
         rst_b <= 1'b1;
         for (i = 0; i < 40 && sys_rst_release !== 1'b1; i = i + 1) @(posedge ref_clk);
         cmp("release", 1, sys_rst_release);
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task rd(input [31:0] a, input [31:0] e);
      begin
         rq.push_back(e);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task key(input [7:0] k);
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            swdio_in <= k[i];
            swclk <= 1'b0;
            repeat (2) @(posedge ref_clk);
            swclk <= 1'b1;
            repeat (2) @(posedge ref_clk);
         end
         swclk <= 1'b0;
         swdio_in <= ~k[0];
      end
   endtask
   task pk(input [31:0] w0, input [31:0] w1);
      begin
         sq.push_back({ptr, 1'b0, w0});
         sq.push_back({ptr, 1'b1, w1});
         ptr = ptr + 1;
         s_r = 1'b0;
      end
   endtask
   task ev(input a, input x);
      begin
         trc_src <= $urandom;
         trc_dst <= $urandom;
         trc_exc_val <= $urandom;
         trc_atomic <= a;
         trc_exc_ret <= x;
         trc_valid <= 1'b1;
         #1;
         if (on && x) begin
            pk({trc_src[31:1], 1'b0}, {trc_exc_val[31:1], s_r});
            pk({trc_exc_val[31:1], 1'b1}, {trc_dst[31:1], 1'b0});
         end else if (on) pk({trc_src[31:1], a}, {trc_dst[31:1], s_r});
         i = 0;
         do begin
            @(posedge ref_clk);
            i = i + 1;
         end while (trc_ready !== 1'b1 && i < 20);
      end
   endtask
   always @(posedge ref_clk) begin
      rd_d <= reg_rd;
      rnd = $urandom;
      cpu_req <= rnd[0];
      cpu_addr <= rnd[AW:1];
      cpu_we <= rnd[AW+1];
      cpu_wdata <= ~rnd;
      sram_rdata <= rnd;
      if (rd_d) cmp("rdata", rq.pop_front(), reg_rdata);
      cmp("faddr", `DLT_LOCK_FLASH_ADDR, flash_addr);
      cmp("cpu_rd", sram_rdata, cpu_rdata);
      // Processor access that is not stalled must pass straight through
      if (cpu_req && !cpu_wait)
         cmp("cpu", {1'b1, cpu_we, cpu_addr, cpu_wdata}, {sram_en, sram_we, sram_addr, sram_wdata});
      if (sram_en && sram_we && (cpu_wait || !cpu_req || !cpu_we))
         cmp("sram", sq.size() ? sq.pop_front() : 0, {sram_addr, sram_wdata});
   end
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", n_checks, mismatches);
         if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (6000) @(posedge ref_clk);
      mismatches = mismatches + 1;
      end_sim;
   end
   initial begin
      void'($urandom(32'h2309225c));
      boot;
      dap_bus_req <= 1'b1;
      rd(`DLT_ADDR_LOCK, 32'h0000_0001);
      cmp("grant", 0, dap_bus_grant);
      wr(`DLT_ADDR_LOCK, 32'h0000_0000);
      rd(`DLT_ADDR_LOCK, 32'h0000_0001);
      debug_access_enable_pin <= 1'b1;
      key(8'h5A);
      rd(`DLT_ADDR_LOCK, 32'h0000_0001);
      key(8'hA5);
      repeat (8) @(posedge ref_clk);
      debug_access_enable_pin <= 1'b0;
      rd(`DLT_ADDR_LOCK, 32'h0000_0002);
      wr(`DLT_ADDR_LOCK, 32'h0000_0000);
      rd(`DLT_ADDR_LOCK, 32'h0000_0000);
      wr(`DLT_ADDR_LOCK, 32'h0000_0002);
      rd(`DLT_ADDR_LOCK, 32'h0000_0002);
      cmp("grant", 1, dap_bus_grant);
      sc = $urandom;
      wr(`DLT_ADDR_SCRATCH, sc);
      rd(`DLT_ADDR_SCRATCH, sc);
      boot;
      rd(`DLT_ADDR_LOCK, 32'h0000_0000);
      rd(`DLT_ADDR_SCRATCH, 32'h0000_0000);
      wr(`DLT_ADDR_REV, sc);
      rd(`DLT_ADDR_REV, {`DLT_CORE_ECO_DEFAULT, `DLT_DEV_REV_DEFAULT});
      rd(32'h41F0_0048, 32'h0000_0000);
      ptr = $urandom;
      wr(`DLT_ADDR_TRC_POS, {17'h0, ptr, 3'h0});
      ev(1'b0, 1'b0);
      trc_valid <= 1'b0;
      wr(`DLT_ADDR_TRC_CTRL, 32'h8000_0000);
      on = 1'b1;
      s_r = 1'b1;
      ev(1'b0, 1'b0);
      ev(1'b1, 1'b0);
      ev(1'b0, 1'b1);
      ev(1'b0, 1'b0);
      trc_valid <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(`DLT_ADDR_TRC_POS, {17'h0, ptr, 3'h0});
      wr(`DLT_ADDR_TRC_CTRL, 32'h0000_0000);
      wr(`DLT_ADDR_TRC_CTRL, 32'h8000_0000);
      s_r = 1'b1;
      ev(1'b1, 1'b0);
      trc_valid <= 1'b0;
      repeat (6) @(posedge ref_clk);
      cmp("left", 0, sq.size());
      end_sim;
   end
endmodule

// >>> src/dlt_top.v
`timescale 1ns/1ps
// Summary of operation
// - Revision register: core ECO code in bits 31:4, device revision in 3:0.
// - Scratch word is read-write and cleared by every reset.
// - After power-up, before system reset release, read flash lock word.
// - Lock word not erased pattern sets lock flag and disables debug port.
// - While locked, debug port cannot reach any internal bus or memory.
// - Enable pin plus key 0xA5 on debug pins erases flash, then unlocks.
// - Lock bit 1 is read-write override flag, set on override, resets zero.
// - Lock bit 0 is read-only, set by lock found at power-up check, cleared when override erase completes.
// - When enabled, capture processor program-flow changes as SRAM packets.
// - Trace packet writes always win SRAM over processor accesses.
// - Processor SRAM access has no wait unless a trace write collides.
// - Only program-flow packets are recorded, no load or store data.
// - Each non-sequential PC change emits one two-word packet; exception return emits two.
// - First word, even address: source bits 31:1, atomic flag in bit 0.
// - Atomic flag set for exception or debug PC update, else clear.
// - Second word, odd address: destination bits 31:1, start flag in bit 0.
// - Start flag set only in first packet after each trace start.
// - Atomic set: source is preferred return address; clear: branch address.
// - Exception return first packet: return instruction to return value, atomic 0.
// - Exception return second packet: return value to resume address, atomic 1.
// - Write pointer addresses unused double word, advances after each packet.
// - Packets written only for events taken while trace enable is 1, at the pointer.
`include "dlt_defines.vh"

module dlt_top #(
   parameter [27:0] CORE_ECO = `DLT_CORE_ECO_DEFAULT,
   parameter [3:0] DEV_REV = `DLT_DEV_REV_DEFAULT,
   parameter [31:0] LOCK_FLASH_ADDR = `DLT_LOCK_FLASH_ADDR,
   parameter AW = 13
) (
   input wire ref_clk,
   input wire rst_b,
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   output reg sys_rst_release,
   output reg flash_rd_req,
   output wire [31:0] flash_addr,
   input wire [31:0] flash_rdata,
   input wire flash_rd_ack,
   output reg flash_erase_req,
   input wire flash_erase_done,
   input wire debug_access_enable_pin,
   input wire swclk,
   input wire swdio_in,
   input wire dap_bus_req,
   output wire dap_bus_grant,
   output wire debug_port_enable,
   input wire trc_valid,
   output wire trc_ready,
   input wire trc_exc_ret,
   input wire trc_atomic,
   input wire [31:0] trc_src,
   input wire [31:0] trc_dst,
   input wire [31:0] trc_exc_val,
   input wire cpu_req,
   input wire cpu_we,
   input wire [AW-1:0] cpu_addr,
   input wire [31:0] cpu_wdata,
   output wire [31:0] cpu_rdata,
   output wire cpu_wait,
   output wire sram_en,
   output wire sram_we,
   output wire [AW-1:0] sram_addr,
   output wire [31:0] sram_wdata,
   input wire [31:0] sram_rdata
);

   localparam [3:0] L_BOOT = 4'b0001;
   localparam [3:0] L_WAIT = 4'b0010;
   localparam [3:0] L_RUN = 4'b0100;
   localparam [3:0] L_ERASE = 4'b1000;
   localparam [2:0] T_IDLE = 3'b001;
   localparam [2:0] T_SRC = 3'b010;
   localparam [2:0] T_DST = 3'b100;

   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n = rst_s2_r;

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   reg [3:0] lst_r;
   reg [3:0] lst_nxt;
   reg lock_state_flag_r;
   reg over_r;
   reg [31:0] scratch_r;
   reg trc_en_r;
   reg [AW-2:0] ptr_r;
   reg [2:0] tst_r;
   reg [7:0] key_sh_r;
   reg [3:0] key_cnt_r;
   reg swclk_d_r;
   reg key_hit_r;

   // Lock check state machine
   always @* begin
      lst_nxt = lst_r;
      case (lst_r)
         L_BOOT: lst_nxt = L_WAIT;
         L_WAIT: if (flash_rd_ack) lst_nxt = L_RUN;
         L_RUN: if (key_hit_r) lst_nxt = L_ERASE;
         L_ERASE: if (flash_erase_done) lst_nxt = L_RUN;
         default: lst_nxt = L_BOOT;
      endcase
   end

   assign flash_addr = LOCK_FLASH_ADDR;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lst_r <= L_BOOT;
         flash_rd_req <= 1'b0;
         sys_rst_release <= 1'b0;
      end else begin
         lst_r <= lst_nxt;
         flash_rd_req <= (lst_nxt == L_WAIT);
         if (lst_r == L_WAIT && flash_rd_ack) begin
            sys_rst_release <= 1'b1;
         end
      end
   end

   wire swclk_rise = swclk & ~swclk_d_r;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         swclk_d_r <= 1'b0;
         key_sh_r <= 8'h00;
         key_cnt_r <= 4'h0;
         key_hit_r <= 1'b0;
      end else begin
         swclk_d_r <= swclk;
         key_hit_r <= 1'b0;
         if (!debug_access_enable_pin || !lock_state_flag_r || lst_r != L_RUN) begin
            key_cnt_r <= 4'h0;
         end else if (swclk_rise) begin
            key_sh_r <= {key_sh_r[6:0], swdio_in};
            if (key_cnt_r == 4'h7) begin
               key_cnt_r <= 4'h0;
               key_hit_r <= ({key_sh_r[6:0], swdio_in} == `DLT_OVERRIDE_KEY);
            end else begin
               key_cnt_r <= key_cnt_r + 4'h1;
            end
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_erase_req <= 1'b0;
      end else begin
         flash_erase_req <= (lst_r == L_RUN) && key_hit_r;
      end
   end

   wire lock_wr = reg_wr && (reg_addr == `DLT_ADDR_LOCK);
   wire erase_fin = (lst_r == L_ERASE) && flash_erase_done;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_state_flag_r <= 1'b0;
         over_r <= 1'b0;
      end else begin
         if (lst_r == L_WAIT && flash_rd_ack) begin
            lock_state_flag_r <= (flash_rdata[15:0] != `DLT_LOCK_ERASED);
         end else if (erase_fin) begin
            lock_state_flag_r <= 1'b0;
         end
         if (erase_fin) begin
            over_r <= 1'b1;
         end else if (lock_wr) begin
            over_r <= reg_wdata[`DLT_LOCK_OVER_BIT];
         end
      end
   end

   assign debug_port_enable = sys_rst_release & ~lock_state_flag_r;
   assign dap_bus_grant = dap_bus_req & debug_port_enable;

   reg [31:0] p_src_r;
   reg [31:0] p_dst_r;
   reg p_a_r;
   reg [31:0] q_src_r;
   reg [31:0] q_dst_r;
   reg q_pend_r;
   reg start_pend_r;
   reg [2:0] tst_nxt;
   wire trc_take = trc_valid & trc_ready;

   // Holds the source while a packet is in flight; no extra queue
   assign trc_ready = (tst_r == T_IDLE);

   always @* begin
      tst_nxt = tst_r;
      case (tst_r)
         T_IDLE: if (trc_valid && trc_en_r) tst_nxt = T_SRC;
         T_SRC: tst_nxt = T_DST;
         T_DST: tst_nxt = q_pend_r ? T_SRC : T_IDLE;
         default: tst_nxt = T_IDLE;
      endcase
   end

   wire ctrl_wr = reg_wr && (reg_addr == `DLT_ADDR_TRC_CTRL);
   wire pos_wr = reg_wr && (reg_addr == `DLT_ADDR_TRC_POS);
   wire pkt_done = (tst_r == T_DST);

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tst_r <= T_IDLE;
         p_src_r <= 32'h0000_0000;
         p_dst_r <= 32'h0000_0000;
         p_a_r <= 1'b0;
         q_src_r <= 32'h0000_0000;
         q_dst_r <= 32'h0000_0000;
         q_pend_r <= 1'b0;
      end else begin
         tst_r <= tst_nxt;
         if (trc_take && trc_en_r) begin
            if (trc_exc_ret) begin
               p_src_r <= trc_src;
               p_dst_r <= trc_exc_val;
               p_a_r <= 1'b0;
               q_src_r <= trc_exc_val;
               q_dst_r <= trc_dst;
               q_pend_r <= 1'b1;
            end else begin
               // Core supplies source per atomic state
               p_src_r <= trc_src;
               p_dst_r <= trc_dst;
               p_a_r <= trc_atomic;
               q_pend_r <= 1'b0;
            end
         end else if (pkt_done && q_pend_r) begin
            p_src_r <= q_src_r;
            p_dst_r <= q_dst_r;
            p_a_r <= 1'b1;
            q_pend_r <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trc_en_r <= 1'b0;
         start_pend_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            trc_en_r <= reg_wdata[`DLT_TRC_EN_BIT];
         end
         if (ctrl_wr && reg_wdata[`DLT_TRC_EN_BIT] && !trc_en_r) begin
            start_pend_r <= 1'b1;
         end else if (pkt_done) begin
            start_pend_r <= 1'b0;
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= {(AW-1){1'b0}};
      end else if (pkt_done) begin
         ptr_r <= ptr_r + {{(AW-2){1'b0}}, 1'b1};
      end else if (pos_wr) begin
         ptr_r <= reg_wdata[AW+1:3];
      end
   end

   wire trace_wr = (tst_r == T_SRC) || (tst_r == T_DST);
   wire [31:0] trace_word = (tst_r == T_SRC) ? {p_src_r[31:1], p_a_r} : {p_dst_r[31:1], start_pend_r};
   wire [AW-1:0] trace_addr = {ptr_r, (tst_r == T_DST)};

   assign sram_en = trace_wr | cpu_req;
   assign sram_we = trace_wr ? 1'b1 : cpu_we;
   assign sram_addr = trace_wr ? trace_addr : cpu_addr;
   assign sram_wdata = trace_wr ? trace_word : cpu_wdata;
   assign cpu_rdata = sram_rdata;
   assign cpu_wait = cpu_req & trace_wr;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         scratch_r <= `DLT_SCRATCH_RESET;
      end else if (reg_wr && reg_addr == `DLT_ADDR_SCRATCH) begin
         scratch_r <= reg_wdata;
      end
   end

   // Read mux, unmapped reads zero
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (reg_addr)
         `DLT_ADDR_REV: rd_nxt = {CORE_ECO, DEV_REV};
         `DLT_ADDR_SCRATCH: rd_nxt = scratch_r;
         `DLT_ADDR_LOCK: rd_nxt = {30'h0000_0000, over_r, lock_state_flag_r};
         `DLT_ADDR_TRC_CTRL: rd_nxt = {trc_en_r, 31'h0000_0000};
         `DLT_ADDR_TRC_POS: rd_nxt = {{(29-AW+1){1'b0}}, ptr_r, 3'h0};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule
